/* core/lwc_location_watch.v */
// Location watch, 64-bit event counter and broadcast pulse generator, AHB-Lite slave
//
// What this block does
// - A32 and A64 cycles compare base against address bits 31 to 5.
// - A24 cycles compare only address bits 23 to 5.
// - A16 cycles compare only address bits 15 to 5.
// - Watch reports matches only while attribute bit 7 is set.
// - Space field 000 A16, 001 A24, 010 A32, 100 A64; others reserved.
// - User cycles accepted only when attribute bit 2 is set.
// - Supervisor cycles accepted only when attribute bit 3 is set.
// - Program cycles accepted only when attribute bit 1 is set.
// - Data cycles accepted only when attribute bit 0 is set.
// - A 64-bit counter counts events on interrupt input line one or two.
// - Counter readable and writable as two 32-bit halves to preset it.
// - Pulse ends and pulse counter clears when the counter plus one equals the programmed width.
// - Pulse counter advances one step per clk_sys cycle, 50 ns (30 ns rounded up to whole clocks).
// - Pulse width field resets to 0x0022.
// - Writing zero to the pulse width is ignored.
// - Source select 00 off, 01 line one, 10 line two, 11 reserved.
// - Writing one to the trigger in pulse mode starts a pulse; reads zero.
// - Pulse active status reads high while a pulse is driven.
`timescale 1ns/100ps
`include "lwc_consts.vh"
module lwc_location_watch #(
  parameter PULSE_W = 16,
  parameter FILTER_LEN = `LWC_FILTER_SAMPLES
) (
  input wire clk_sys,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire vmeCycleStrobe,
  input wire [31:0] vmeAddr,
  input wire [2:0] vmeSpace,
  input wire vmeSupervisor,
  input wire vmeProgram,
  input wire irq1InLow,
  input wire irq2InLow,
  output reg irq1OutEn,
  output reg irq2OutEn,
  output reg watchHit
);

  localparam integer STEP_CYC = `LWC_STEP_CYCLES;
  localparam [31:0] STEP_LAST_FULL = STEP_CYC - 1;
  localparam [7:0] STEP_LAST = STEP_LAST_FULL[7:0];

  // Register state
  reg [31:0] baseLow;
  reg [`LWC_ATTR_WIDTH-1:0] attributes;
  reg [31:0] countHigh, countLow;
  reg [PULSE_W-1:0] pulseWidth;
  reg [1:0] counterSource, line1Func, line2Func;
  reg hitFlag;

  // Pulse generator state
  reg pulseActive;
  reg [PULSE_W-1:0] pulseCount;
  reg [7:0] stepCount;

  // Bus state
  reg wrPend, rdPend;
  reg [11:0] wrAddr, rdAddr;

  // Combinational terms
  wire addrPhase;
  wire [1:0] lineEdge;
  wire stepTick, countEvent, pulseStart;
  wire wrBaseLow, wrAttributes, wrCountHigh, wrCountLow, wrPulseTimer, wrPulseCtrl, wrStatus;
  wire spaceMatch, privAccept, typeAccept, addrMatch, hitNow;
  reg [31:0] cmpMask;
  reg spaceKnown;
  reg [63:0] next_count;
  reg next_pulseActive;
  reg [PULSE_W-1:0] next_pulseCount;
  reg [31:0] next_rdata;
  reg [1:0] next_line1Func, next_line2Func;

  assign addrPhase = hsel && htrans[1] && hready;

  // Input filters, one per interrupt input line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : gLine
      lwc_irq_filter #(
        .FILTER_LEN(FILTER_LEN)
      ) uFilter (
        .clk_sys(clk_sys),
        .rst(rst),
        .lineLow(gi == 0 ? irq1InLow : irq2InLow),
        .edgeSeen(lineEdge[gi])
      );
    end
  endgenerate

  // Write strobes in the data phase
  assign wrBaseLow = wrPend && (wrAddr == `LWC_OFS_BASE_LOW);
  assign wrAttributes = wrPend && (wrAddr == `LWC_OFS_ATTRIBUTES);
  assign wrCountHigh = wrPend && (wrAddr == `LWC_OFS_COUNT_HIGH);
  assign wrCountLow = wrPend && (wrAddr == `LWC_OFS_COUNT_LOW);
  assign wrPulseTimer = wrPend && (wrAddr == `LWC_OFS_PULSE_TIMER);
  assign wrPulseCtrl = wrPend && (wrAddr == `LWC_OFS_PULSE_CTRL);
  assign wrStatus = wrPend && (wrAddr == `LWC_OFS_WATCH_STATUS);

  // Location compare width per monitored space
  always @*
  begin
    cmpMask = 32'h00000000;
    spaceKnown = 1'b1;
    case (attributes[`LWC_ATTR_SPACE_HI:`LWC_ATTR_SPACE_LO])
      `LWC_SPACE_A16: cmpMask = `LWC_MASK_A16;
      `LWC_SPACE_A24: cmpMask = `LWC_MASK_A24;
      `LWC_SPACE_A32: cmpMask = `LWC_MASK_A32;
      `LWC_SPACE_A64: cmpMask = `LWC_MASK_A32;
      default: spaceKnown = 1'b0;
    endcase
  end

  assign spaceMatch = spaceKnown &&
    (vmeSpace == attributes[`LWC_ATTR_SPACE_HI:`LWC_ATTR_SPACE_LO]);
  assign privAccept = vmeSupervisor ? attributes[`LWC_ATTR_SUPERVISOR]
    : attributes[`LWC_ATTR_USER];
  assign typeAccept = vmeProgram ? attributes[`LWC_ATTR_PROGRAM]
    : attributes[`LWC_ATTR_DATA];
  assign addrMatch = (((vmeAddr ^ baseLow) & cmpMask) == 32'h00000000);
  assign hitNow = vmeCycleStrobe && attributes[`LWC_ATTR_ENABLE] && spaceMatch
    && privAccept && typeAccept && addrMatch;

  // Event counter source
  assign countEvent = ((counterSource == `LWC_SOURCE_LINE1) && lineEdge[0]) ||
    ((counterSource == `LWC_SOURCE_LINE2) && lineEdge[1]);

  // Counter next value; a preset write wins over a coincident event in the half it writes
  always @*
  begin
    next_count = {countHigh, countLow};
    if (countEvent)
    begin
      next_count = next_count + 64'h0000000000000001;
    end
    if (wrCountLow)
    begin
      next_count[31:0] = hwdata;
    end
    if (wrCountHigh)
    begin
      next_count[63:32] = hwdata;
    end
  end

  // Pulse steps
  assign stepTick = (stepCount == STEP_LAST);
  always @(posedge clk_sys)
  begin
    if (rst || !pulseActive || stepTick)
    begin
      stepCount <= 8'h00;
    end
    else
    begin
      stepCount <= stepCount + 8'h01;
    end
  end

  // Function fields as they stand after this cycle
  always @*
  begin
    next_line1Func = line1Func;
    next_line2Func = line2Func;
    if (wrPulseCtrl)
    begin
      next_line1Func = hwdata[`LWC_CTRL_LINE1_HI:`LWC_CTRL_LINE1_LO];
      next_line2Func = hwdata[`LWC_CTRL_LINE2_HI:`LWC_CTRL_LINE2_LO];
    end
  end

  // Trigger only in pulse mode and only while idle
  assign pulseStart = wrPulseCtrl && hwdata[`LWC_CTRL_TRIGGER] && !pulseActive &&
    ((next_line1Func == `LWC_FUNC_PULSE) || (next_line2Func == `LWC_FUNC_PULSE));

  always @*
  begin
    next_pulseActive = pulseActive;
    next_pulseCount = pulseCount;
    if (pulseStart)
    begin
      next_pulseActive = 1'b1;
      next_pulseCount = {PULSE_W{1'b0}};
    end
    else if (pulseActive && stepTick)
    begin
      if ((pulseCount + 1'b1) == pulseWidth)
      begin
        next_pulseActive = 1'b0;
        next_pulseCount = {PULSE_W{1'b0}};
      end
      else
      begin
        next_pulseCount = pulseCount + 1'b1;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pulseActive <= 1'b0;
      pulseCount <= {PULSE_W{1'b0}};
      irq1OutEn <= 1'b0;
      irq2OutEn <= 1'b0;
    end
    else
    begin
      pulseActive <= next_pulseActive;
      pulseCount <= next_pulseCount;
      irq1OutEn <= next_pulseActive && (next_line1Func == `LWC_FUNC_PULSE);
      irq2OutEn <= next_pulseActive && (next_line2Func == `LWC_FUNC_PULSE);
    end
  end

  // Register writes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      baseLow <= `LWC_RST_BASE_LOW;
      attributes <= `LWC_RST_ATTRIBUTES;
      countHigh <= `LWC_RST_COUNT;
      countLow <= `LWC_RST_COUNT;
      pulseWidth <= `LWC_RST_PULSE_WIDTH;
      counterSource <= `LWC_SOURCE_OFF;
      line1Func <= `LWC_RST_FUNC;
      line2Func <= `LWC_RST_FUNC;
      hitFlag <= 1'b0;
      watchHit <= 1'b0;
    end
    else
    begin
      countHigh <= next_count[63:32];
      countLow <= next_count[31:0];
      line1Func <= next_line1Func;
      line2Func <= next_line2Func;
      watchHit <= hitNow;
      if (wrBaseLow)
      begin
        baseLow <= {hwdata[31:`LWC_BASE_LSB], 5'h00};
      end
      if (wrAttributes)
      begin
        attributes <= hwdata[`LWC_ATTR_WIDTH-1:0];
      end
      if (wrPulseTimer && (hwdata[PULSE_W-1:0] != {PULSE_W{1'b0}}))
      begin
        pulseWidth <= hwdata[PULSE_W-1:0];
      end
      if (wrPulseCtrl)
      begin
        counterSource <= hwdata[`LWC_CTRL_SOURCE_HI:`LWC_CTRL_SOURCE_LO];
      end
      // Set wins over a write-one clear
      if (hitNow)
      begin
        hitFlag <= 1'b1;
      end
      else if (wrStatus && hwdata[`LWC_STATUS_HIT])
      begin
        hitFlag <= 1'b0;
      end
    end
  end

  // Read data selection
  always @*
  begin
    next_rdata = 32'h00000000;
    if (rdAddr == `LWC_OFS_BASE_LOW)
    begin
      next_rdata = baseLow;
    end
    else if (rdAddr == `LWC_OFS_ATTRIBUTES)
    begin
      next_rdata[`LWC_ATTR_WIDTH-1:0] = attributes;
    end
    else if (rdAddr == `LWC_OFS_COUNT_HIGH)
    begin
      next_rdata = countHigh;
    end
    else if (rdAddr == `LWC_OFS_COUNT_LOW)
    begin
      next_rdata = countLow;
    end
    else if (rdAddr == `LWC_OFS_PULSE_TIMER)
    begin
      next_rdata[PULSE_W-1:0] = pulseWidth;
    end
    else if (rdAddr == `LWC_OFS_PULSE_CTRL)
    begin
      next_rdata[`LWC_CTRL_SOURCE_HI:`LWC_CTRL_SOURCE_LO] = counterSource;
      next_rdata[`LWC_CTRL_LINE1_HI:`LWC_CTRL_LINE1_LO] = line1Func;
      next_rdata[`LWC_CTRL_LINE2_HI:`LWC_CTRL_LINE2_LO] = line2Func;
      next_rdata[`LWC_CTRL_ACTIVE] = pulseActive;
    end
    else if (rdAddr == `LWC_OFS_WATCH_STATUS)
    begin
      next_rdata[`LWC_STATUS_HIT] = hitFlag;
    end
  end

  // AHB-Lite slave: writes without wait, reads with one wait state
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
      rdPend <= 1'b0;
      rdAddr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      hresp <= 1'b0;
      wrPend <= addrPhase && hwrite;
      if (addrPhase)
      begin
        wrAddr <= {haddr[11:2], 2'b00};
        rdAddr <= {haddr[11:2], 2'b00};
      end
      if (addrPhase && !hwrite)
      begin
        rdPend <= 1'b1;
        hreadyout <= 1'b0;
      end
      else if (rdPend)
      begin
        rdPend <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= next_rdata;
      end
      else
      begin
        hreadyout <= 1'b1;
      end
    end
  end

endmodule // lwc_location_watch

/* shared/lwc_consts.vh */
// Offsets, field positions, reset values and timing of the location watch block
`ifndef LWC_CONSTS_VH
`define LWC_CONSTS_VH

// Register byte offsets (bits 11:0 of haddr)
`define LWC_OFS_BASE_LOW 12'h428
`define LWC_OFS_ATTRIBUTES 12'h42C
`define LWC_OFS_COUNT_HIGH 12'h430
`define LWC_OFS_COUNT_LOW 12'h434
`define LWC_OFS_PULSE_TIMER 12'h438
`define LWC_OFS_PULSE_CTRL 12'h440
`define LWC_OFS_WATCH_STATUS 12'h444

// Location watch base and attribute fields
`define LWC_BASE_LSB 5
`define LWC_ATTR_WIDTH 8
`define LWC_ATTR_ENABLE 7
`define LWC_ATTR_SPACE_HI 6
`define LWC_ATTR_SPACE_LO 4
`define LWC_ATTR_SUPERVISOR 3
`define LWC_ATTR_USER 2
`define LWC_ATTR_PROGRAM 1
`define LWC_ATTR_DATA 0

// Address space codes
`define LWC_SPACE_A16 3'h0
`define LWC_SPACE_A24 3'h1
`define LWC_SPACE_A32 3'h2
`define LWC_SPACE_A64 3'h4

// Compare masks per space
`define LWC_MASK_A16 32'h0000FFE0
`define LWC_MASK_A24 32'h00FFFFE0
`define LWC_MASK_A32 32'hFFFFFFE0

// Pulse control fields
`define LWC_CTRL_SOURCE_HI 31
`define LWC_CTRL_SOURCE_LO 30
`define LWC_CTRL_LINE1_HI 27
`define LWC_CTRL_LINE1_LO 26
`define LWC_CTRL_LINE2_HI 25
`define LWC_CTRL_LINE2_LO 24
`define LWC_CTRL_TRIGGER 23
`define LWC_CTRL_ACTIVE 22
`define LWC_SOURCE_OFF 2'h0
`define LWC_SOURCE_LINE1 2'h1
`define LWC_SOURCE_LINE2 2'h2
`define LWC_FUNC_PULSE 2'h1

// Watch status fields
`define LWC_STATUS_HIT 0

// Reset values
`define LWC_RST_BASE_LOW 32'h00000000
`define LWC_RST_ATTRIBUTES 8'h00
`define LWC_RST_COUNT 32'h00000000
`define LWC_RST_PULSE_WIDTH 16'h0022
`define LWC_RST_FUNC 2'h0

// Timing
`define LWC_CLK_PERIOD_NS 50
`define LWC_STEP_NS 30
`define LWC_STEP_CYCLES (((`LWC_STEP_NS + `LWC_CLK_PERIOD_NS - 1) / `LWC_CLK_PERIOD_NS) < 1 ? 1 : ((`LWC_STEP_NS + `LWC_CLK_PERIOD_NS - 1) / `LWC_CLK_PERIOD_NS))
`define LWC_FILTER_SAMPLES 3

`endif

/* core/lwc_irq_filter.v */
// Glitch filter and falling-edge detector for one active-low interrupt input
`timescale 1ns/100ps
module lwc_irq_filter #(
  parameter FILTER_LEN = 3
) (
  input wire clk_sys,
  input wire rst,
  input wire lineLow,
  output reg edgeSeen
);

  reg [FILTER_LEN-1:0] history;
  reg stableLevel;

  // A level counts only after FILTER_LEN equal samples
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      history <= {FILTER_LEN{1'b1}};
      stableLevel <= 1'b1;
      edgeSeen <= 1'b0;
    end
    else
    begin
      history <= {history[FILTER_LEN-2:0], lineLow};
      edgeSeen <= 1'b0;
      if (stableLevel && (history == {FILTER_LEN{1'b0}}))
      begin
        stableLevel <= 1'b0;
        edgeSeen <= 1'b1;
      end
      else if (history == {FILTER_LEN{1'b1}})
      begin
        stableLevel <= 1'b1;
      end
    end
  end

endmodule // lwc_irq_filter

/* verif/lwc_watch_props.sv */
// Port assertions for the location watch block
`timescale 1ns/100ps
`include "lwc_consts.vh"
module lwc_watch_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic vmeCycleStrobe,
  input wire logic [31:0] vmeAddr,
  input wire logic [2:0] vmeSpace,
  input wire logic vmeSupervisor,
  input wire logic vmeProgram,
  input wire logic irq1OutEn,
  input wire logic irq2OutEn,
  input wire logic watchHit
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic wr;
  logic [11:0] ofs;
  logic [31:0] base;
  logic [7:0] attr;
  logic [15:0] width;
  logic [15:0] run;
  wire anyOut = irq1OutEn | irq2OutEn;
  wire [31:0] mask = vmeSpace == 3'h0 ? `LWC_MASK_A16 :
    vmeSpace == 3'h1 ? `LWC_MASK_A24 : `LWC_MASK_A32;
  wire hitNow = attr[7] && attr[6:4] == vmeSpace && vmeSpace != 3'h3 && vmeSpace < 3'h5
    && (vmeSupervisor ? attr[3] : attr[2]) && (vmeProgram ? attr[1] : attr[0])
    && ((vmeAddr ^ base) & mask) == 32'h0;
  // Shadow of the registers the assertions depend on
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr <= 1'b0;
      ofs <= 12'h0;
      base <= 32'h0;
      attr <= 8'h0;
      width <= `LWC_RST_PULSE_WIDTH;
      run <= 16'h0;
    end
    else
    begin
      if (hready)
      begin
        wr <= hsel && htrans[1] && hwrite;
        ofs <= haddr[11:0];
      end
      if (wr && hready && ofs == `LWC_OFS_BASE_LOW)
        base <= hwdata;
      if (wr && hready && ofs == `LWC_OFS_ATTRIBUTES)
        attr <= hwdata[7:0];
      if (wr && hready && ofs == `LWC_OFS_PULSE_TIMER && hwdata[15:0] != 16'h0)
        width <= hwdata[15:0];
      run <= anyOut ? run + 16'h1 : 16'h0;
    end
  end
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_hit_enable: assert property (watchHit |-> $past(attr[7])) else $error("hit disabled");
  a_hit_space: assert property (watchHit |-> $past(attr[6:4]) == $past(vmeSpace))
    else $error("hit wrong space");
  a_hit_privilege: assert property (watchHit |-> ($past(vmeSupervisor) ? $past(attr[3])
    : $past(attr[2]))) else $error("hit wrong privilege");
  a_hit_cycle_type: assert property (watchHit |-> ($past(vmeProgram) ? $past(attr[1])
    : $past(attr[0]))) else $error("hit wrong type");
  a_hit_address: assert property (watchHit |-> (($past(vmeAddr) ^ $past(base))
    & $past(mask)) == 32'h0) else $error("hit wrong address");
  a_hit_exact: assert property (watchHit == $past(vmeCycleStrobe && hitNow))
    else $error("hit mismatch");
  a_pulse_width: assert property ($fell(anyOut) |-> run == width * (`LWC_STEP_CYCLES))
    else $error("pulse width");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> s_wait)
    else $error("read wait");
  a_write_ready: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write wait");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response");
endmodule // lwc_watch_props

bind lwc_location_watch lwc_watch_props i_lwc_watch_props (.clk_sys, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .vmeCycleStrobe, .vmeAddr,
  .vmeSpace, .vmeSupervisor, .vmeProgram, .irq1OutEn, .irq2OutEn, .watchHit);

/* verif/lwc_vme_master.sv */
// Far side model: bus cycles and pulled-up interrupt input lines
`timescale 1ns/100ps
module lwc_vme_master (
  input wire logic clk_sys,
  output logic vmeCycleStrobe = 1'b0,
  output logic [31:0] vmeAddr = 32'h0,
  output logic [2:0] vmeSpace = 3'h0,
  output logic vmeSupervisor = 1'b0,
  output logic vmeProgram = 1'b0,
  output logic irq1InLow = 1'b1,
  output logic irq2InLow = 1'b1
);
  // One-cycle strobe; lines scrambled once unqualified
  task automatic cycle(input logic [31:0] a, input logic [2:0] s, input logic su,
    input logic pg);
    @(posedge clk_sys);
    vmeCycleStrobe <= 1'b1;
    vmeAddr <= a;
    vmeSpace <= s;
    vmeSupervisor <= su;
    vmeProgram <= pg;
    @(posedge clk_sys);
    vmeCycleStrobe <= 1'b0;
    vmeAddr <= ~a;
    vmeSpace <= ~s;
    vmeSupervisor <= ~su;
    vmeProgram <= ~pg;
  endtask
  // Line pulled low for n clocks, then a quiet gap
  task automatic pulse(input logic two, input int n);
    @(posedge clk_sys);
    if (two)
      irq2InLow <= 1'b0;
    else
      irq1InLow <= 1'b0;
    repeat (n) @(posedge clk_sys);
    irq1InLow <= 1'b1;
    irq2InLow <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // lwc_vme_master

/* verif/tb_top.sv */
// Self-checking bench for the location watch block
`timescale 1ns/100ps
`include "lwc_consts.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] lfsr = 16'hBF03;
  logic [31:0] run1 = 32'h0;
  logic [31:0] run2 = 32'h0;
  logic runClear = 1'b0;
  int numErrors = 0;
  int numChecks = 0;
  int cycles = 0;
  wire hreadyout, hresp, irq1OutEn, irq2OutEn, watchHit, vmeCycleStrobe;
  wire vmeSupervisor, vmeProgram, irq1InLow, irq2InLow;
  wire [31:0] hrdata, vmeAddr;
  wire [2:0] vmeSpace;
  lwc_location_watch i_lwc_location_watch (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vmeCycleStrobe,
    .vmeAddr, .vmeSpace, .vmeSupervisor, .vmeProgram, .irq1InLow, .irq2InLow, .irq1OutEn,
    .irq2OutEn, .watchHit);
  lwc_vme_master i_lwc_vme_master (.clk_sys, .vmeCycleStrobe, .vmeAddr, .vmeSpace,
    .vmeSupervisor, .vmeProgram, .irq1InLow, .irq2InLow);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (runClear)
    begin
      run1 <= 32'h0;
      run2 <= 32'h0;
    end
    else
    begin
      if (irq1OutEn === 1'b1)
        run1 <= run1 + 32'h1;
      if (irq2OutEn === 1'b1)
        run2 <= run2 + 32'h1;
    end
    if (cycles == 4000)
    begin
      numErrors = numErrors + 1;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [31:0] maskOf(input logic [2:0] s);
    return s == 3'h0 ? `LWC_MASK_A16 : s == 3'h1 ? `LWC_MASK_A24 : `LWC_MASK_A32;
  endfunction
  function automatic logic expHit(input logic [7:0] t, input logic [31:0] b,
    input logic [31:0] a, input logic [2:0] s, input logic su, input logic pg);
    return t[7] && t[6:4] == s && s != 3'h3 && s < 3'h5 && (su ? t[3] : t[2])
      && (pg ? t[1] : t[0])
      && ((a ^ b) & maskOf(s)) == 32'h0;
  endfunction
  task automatic chkWord(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkBit(input logic g, input logic e);
    numChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] o, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, o};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, o, d, r);
  endtask
  task automatic rd(input logic [11:0] o, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, o, 32'h0, r);
    chkWord(r, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    logic [31:0] v, b, a, q;
    logic [63:0] e64;
    logic [15:0] r, w;
    logic [7:0] t;
    logic [2:0] sp;
    logic e, f, ln;
    int k;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`LWC_OFS_BASE_LOW, 32'h0);
    rd(`LWC_OFS_ATTRIBUTES, 32'h0);
    rd(`LWC_OFS_COUNT_LOW, 32'h0);
    rd(`LWC_OFS_PULSE_TIMER, 32'h22);
    v = {rnd(), rnd()};
    wr(`LWC_OFS_BASE_LOW, v);
    rd(`LWC_OFS_BASE_LOW, v & 32'hFFFFFFE0);
    wr(`LWC_OFS_ATTRIBUTES, v);
    rd(`LWC_OFS_ATTRIBUTES, v & 32'hFF);
    wr(`LWC_OFS_PULSE_TIMER, 32'h0);
    rd(`LWC_OFS_PULSE_TIMER, 32'h22);
    wr(12'h43C, v);
    rd(12'h43C, 32'h0);
    $display("test registers done");
    for (k = 0; k < 60; k++)
    begin
      r = rnd();
      q = {rnd(), rnd()};
      b = {rnd(), rnd()};
      sp = r[1:0] == 2'h3 ? (q[3] ? 3'h4 : q[6:4] | 3'h3) : {1'b0, r[1:0]};
      t = {r[2] | r[3], r[4] ? sp : r[7:5], r[11:8] | r[15:12]};
      a = q[0] ? b ^ (q & ~maskOf(sp)) : q;
      e = expHit(t, b, a, sp, q[1], q[2]);
      wr(`LWC_OFS_BASE_LOW, b);
      wr(`LWC_OFS_ATTRIBUTES, {24'h0, t});
      i_lwc_vme_master.cycle(a, sp, q[1], q[2]);
      @(posedge clk_sys);
      chkBit(watchHit, e);
      rd(`LWC_OFS_WATCH_STATUS, {31'h0, e});
      wr(`LWC_OFS_WATCH_STATUS, 32'h1);
    end
    $display("test watch done");
    for (k = 0; k < 4; k++)
    begin
      v = {rnd(), rnd()};
      wr(`LWC_OFS_PULSE_CTRL, k << 30);
      wr(`LWC_OFS_COUNT_HIGH, v);
      wr(`LWC_OFS_COUNT_LOW, 32'hFFFFFFFF);
      i_lwc_vme_master.pulse(1'b0, 2);
      i_lwc_vme_master.pulse(1'b0, 5);
      i_lwc_vme_master.pulse(1'b1, 5);
      e64 = {v, 32'hFFFFFFFF} + ((k == 1 || k == 2) ? 64'h1 : 64'h0);
      rd(`LWC_OFS_COUNT_LOW, e64[31:0]);
      rd(`LWC_OFS_COUNT_HIGH, e64[63:32]);
    end
    $display("test counter done");
    for (k = 0; k < 3; k++)
    begin
      r = rnd();
      w = 16'h0008 + {11'h0, r[4:0]};
      ln = k == 1;
      f = k != 2;
      if (k == 0)
        w = 16'h0022;
      else
        wr(`LWC_OFS_PULSE_TIMER, {16'h0, w});
      v = {31'h0, f} << (ln ? 24 : 26);
      runClear <= 1'b1;
      @(posedge clk_sys);
      runClear <= 1'b0;
      wr(`LWC_OFS_PULSE_CTRL, v | 32'h00800000);
      rd(`LWC_OFS_PULSE_CTRL, v | ({31'h0, f} << 22));
      repeat (w * (`LWC_STEP_CYCLES) + 4) @(posedge clk_sys);
      chkWord(run1, !ln && f ? {16'h0, w} * (`LWC_STEP_CYCLES) : 32'h0);
      chkWord(run2, ln && f ? {16'h0, w} * (`LWC_STEP_CYCLES) : 32'h0);
      rd(`LWC_OFS_PULSE_CTRL, v);
    end
    $display("test pulse done");
    tally_and_finish();
  end
endmodule // tb_top
